/* hw/rtci_host.sv */
`timescale 1ns/100ps
`default_nettype none
module rtci_host (
	input wire logic mclk, // system clock, 20 MHz
	input wire logic rst_n, // async reset, active low
	rtci_if.host bus, // two-wire link
	input wire logic cmdValid, // command offered
	output logic cmdReady, // idle, command taken
	input wire logic cmdRead, // 1 read, 0 write
	input wire logic cmdSetReg, // send register byte first
	input wire logic [7:0] cmdReg, // register byte
	input wire logic [7:0] cmdLen, // data bytes, 1 or more
	input wire logic wrValid, // write byte offered
	input wire logic [7:0] wrData, // write byte
	output logic wrReady, // write byte taken, pulse
	output logic rdValid, // read byte available
	output logic [7:0] rdData, // read byte
	input wire logic rdReady, // read byte drained
	output logic doneStb, // transfer ended, pulse
	output logic nackSeen // target refused a byte
);
	import rtci_pkg::*;

	logic sdaM_q, sdaS_q; // data pin sampler
	logic [2:0] divCnt_q; // quarter-period divider
	logic [1:0] q_q; // quarter within a bit
	rtci_hstate_t state_q;
	rtci_stage_t stage_q;
	logic [3:0] bit_q; // bits done in the byte
	logic [7:0] shift_q, left_q; // byte, bytes still to move
	logic read_q; // latched command direction
	logic [7:0] regB_q; // register byte
	logic sclOe_q, sdaOe_q; // pin drivers
	logic pushV_q; // read byte into buffer
	logic [7:0] pushD_q;
	logic fifoInReady;

	// sampler on the data pin only; the clock is ours
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sdaM_q <= 1'b1;
			sdaS_q <= 1'b1;
		end else begin
			sdaM_q <= bus.sdaLine;
			sdaS_q <= sdaM_q;
		end
	end

	wire slotEnd = q_q == 2'h3 && bit_q == ACK_SLOT;
	wire needWr = (stage_q == S_REG && !read_q) ||
		(stage_q == S_DATA && left_q != 8'h01);
	// a full buffer or a missing write byte freezes the serial clock
	wire stall = (state_q == H_SEND && slotEnd && !sdaS_q && needWr &&
		!wrValid) || (state_q == H_RECV && q_q == 2'h3 &&
		bit_q == LAST_BIT && !fifoInReady);
	wire tick = divCnt_q == QTR_LAST && !stall;
	wire lastByte = left_q == 8'h01;
	// data we put on the line in quarter 1 while the clock is low
	wire sendDrv = bit_q < ACK_SLOT ? !shift_q[7] : 1'b0;
	wire recvDrv = bit_q < ACK_SLOT ? 1'b0 : !lastByte;
	wire [7:0] rxByte = {shift_q[6:0], sdaS_q};

	// divider runs freely, holds in its last count while stalled
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			divCnt_q <= 3'h0;
		else if (divCnt_q != QTR_LAST)
			divCnt_q <= 3'(divCnt_q + 3'h1);
		else if (!stall)
			divCnt_q <= 3'h0;
	end

	// transfer sequencer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= H_IDLE;
			stage_q <= S_ADDRW;
			q_q <= 2'h0;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			left_q <= 8'h00;
			read_q <= 1'b0;
			regB_q <= 8'h00;
			sclOe_q <= 1'b0;
			sdaOe_q <= 1'b0;
			cmdReady <= 1'b1;
			wrReady <= 1'b0;
			doneStb <= 1'b0;
			nackSeen <= 1'b0;
			pushV_q <= 1'b0;
			pushD_q <= 8'h00;
		end else begin
			wrReady <= 1'b0;
			doneStb <= 1'b0;
			pushV_q <= 1'b0;
			if (state_q == H_IDLE) begin
				if (cmdValid && cmdReady) begin
					// a write always names its register first
					read_q <= cmdRead;
					regB_q <= cmdReg;
					left_q <= cmdLen;
					nackSeen <= 1'b0;
					cmdReady <= 1'b0;
					q_q <= 2'h0;
					state_q <= H_START;
					if (cmdRead && !cmdSetReg) begin
						shift_q <= {TGT_ADDR, DIR_READ};
						stage_q <= S_ADDRR;
					end else begin
						shift_q <= {TGT_ADDR, DIR_WRITE};
						stage_q <= S_ADDRW;
					end
				end
			end else if (tick) begin
				q_q <= 2'(q_q + 2'h1);
				case (state_q)
					H_START: begin
						// clock low, data up, clock up, data down
						case (q_q)
							2'h0: sclOe_q <= 1'b1;
							2'h1: sdaOe_q <= 1'b0;
							2'h2: sclOe_q <= 1'b0;
							default: begin
								sdaOe_q <= 1'b1;
								bit_q <= 4'h0;
								state_q <= H_SEND;
							end
						endcase
					end
					H_STOP: begin
						case (q_q)
							2'h0: sclOe_q <= 1'b1;
							2'h1: sdaOe_q <= 1'b1;
							2'h2: sclOe_q <= 1'b0;
							default: begin
								sdaOe_q <= 1'b0;
								state_q <= H_IDLE;
								doneStb <= 1'b1;
								cmdReady <= 1'b1;
							end
						endcase
					end
					default: begin
						// one bit: change while low, sample late while high
						case (q_q)
							2'h0: sclOe_q <= 1'b1;
							2'h1: sdaOe_q <= state_q == H_SEND ?
								sendDrv : recvDrv;
							2'h2: sclOe_q <= 1'b0;
							default: bit_q <= 4'(bit_q + 4'h1);
						endcase
						if (q_q == 2'h3 && state_q == H_SEND &&
							bit_q < ACK_SLOT)
							shift_q <= {shift_q[6:0], 1'b0};
						if (q_q == 2'h3 && state_q == H_RECV &&
							bit_q < ACK_SLOT)
							shift_q <= rxByte;
						if (q_q == 2'h3 && state_q == H_RECV &&
							bit_q == LAST_BIT) begin
							pushV_q <= 1'b1;
							pushD_q <= rxByte;
						end
						if (slotEnd) begin
							bit_q <= 4'h0;
							if (state_q == H_RECV) begin
								left_q <= 8'(left_q - 8'h01);
								if (lastByte)
									state_q <= H_STOP;
							end else if (sdaS_q) begin
								nackSeen <= 1'b1;
								state_q <= H_STOP;
							end else begin
								case (stage_q)
									S_ADDRW: begin
										shift_q <= regB_q;
										stage_q <= S_REG;
									end
									S_REG: begin
										if (read_q) begin
											shift_q <= {TGT_ADDR, DIR_READ};
											stage_q <= S_ADDRR;
											state_q <= H_START;
										end else begin
											shift_q <= wrData;
											wrReady <= 1'b1;
											stage_q <= S_DATA;
										end
									end
									S_DATA: begin
										left_q <= 8'(left_q - 8'h01);
										if (lastByte) begin
											state_q <= H_STOP;
										end else begin
											shift_q <= wrData;
											wrReady <= 1'b1;
										end
									end
									default: begin
										state_q <= H_RECV;
									end
								endcase
							end
						end
					end
				endcase
			end
		end
	end

	// read bytes wait here; a full buffer stalls the clock above
	rtci_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) rdBuf (
		.mclk(mclk),
		.rst_n(rst_n),
		.inValid(pushV_q),
		.inData(pushD_q),
		.inReady(fifoInReady),
		.outValid(rdValid),
		.outData(rdData),
		.outReady(rdReady)
	);

	assign bus.sclHostOe = sclOe_q;
	assign bus.sdaHostOe = sdaOe_q;
endmodule
`default_nettype wire

/* hw/rtci_pkg.sv */
`default_nettype none
package rtci_pkg;
	// fixed target address, sent in the upper seven bits of the first byte
	localparam logic [6:0] TGT_ADDR = 7'h32;
	localparam logic DIR_WRITE = 1'b0; // direction bit 0 selects a write
	localparam logic DIR_READ = 1'b1; // direction bit 1 selects a read
	localparam int BYTE_BITS = 8; // bits per byte on the wire
	localparam logic [3:0] LAST_BIT = 4'h7; // index of the eighth bit
	localparam logic [3:0] ACK_SLOT = 4'h8; // ninth clock carries the ack
	// bit count after a start: the start's own clock fall wraps it to 0
	localparam logic [3:0] BIT_PRE = 4'hf;
	localparam logic [7:0] PTR_RST = 8'h00; // register pointer after reset
	// host serial clock: its own choice, slow enough for two-flop sampling
	localparam int MCLK_NS = 50;
	localparam int HOST_SCL_NS = 1000;
	localparam int QTR_CYC = HOST_SCL_NS / 4 / MCLK_NS;
	localparam logic [2:0] QTR_LAST = 3'(QTR_CYC - 1);
	localparam int FIFO_W = 8; // read data word width
	localparam int FIFO_D = 32; // read data words buffered
	typedef enum {T_IDLE, T_ADDR, T_REG, T_WDATA, T_RDATA, T_IGNORE}
		rtci_tstate_t;
	typedef enum {H_IDLE, H_START, H_SEND, H_RECV, H_STOP} rtci_hstate_t;
	typedef enum {S_ADDRW, S_REG, S_DATA, S_ADDRR} rtci_stage_t;
endpackage
`default_nettype wire

/* hw/rtci_if.sv */
`timescale 1ns/100ps
`default_nettype none
// two-wire link: each end only pulls low, released lines read high
interface rtci_if;
	logic sclHostOe; // host pulls clock low
	logic sdaHostOe; // host pulls data low
	logic sdaDevOe; // target pulls data low
	wire sclLine; // resolved clock level
	wire sdaLine; // resolved data level
	// wired-and with pull-ups
	assign sclLine = !sclHostOe;
	assign sdaLine = !(sdaHostOe || sdaDevOe);
	modport host (output sclHostOe, output sdaHostOe,
		input sclLine, input sdaLine);
	modport dev (output sdaDevOe, input sclLine, input sdaLine);
endinterface
`default_nettype wire

/* hw/rtci_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module rtci_fifo #(
	parameter int WIDTH = rtci_pkg::FIFO_W, // word width
	parameter int DEPTH = rtci_pkg::FIFO_D // words held
) (
	input wire logic mclk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic inValid, // word offered
	input wire logic [WIDTH-1:0] inData, // word in
	output logic inReady, // room for a word
	output logic outValid, // word available
	output logic [WIDTH-1:0] outData, // oldest word
	input wire logic outReady // drain accepts the word
);
	import rtci_pkg::*;
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH]; // storage in flops
	logic [AW-1:0] wp_q, rp_q; // write and read index
	logic [AW:0] cnt_q; // words held
	wire push = inValid && inReady;
	wire pop = outValid && outReady;
	wire [AW:0] cntD = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign outData = mem_q[rp_q];
	// flags registered from the next count so both ports come from flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			inReady <= 1'b1;
			outValid <= 1'b0;
		end else begin
			if (push) wp_q <= AW'(wp_q + 1'b1);
			if (pop) rp_q <= AW'(rp_q + 1'b1);
			cnt_q <= cntD;
			inReady <= cntD != (AW+1)'(DEPTH);
			outValid <= cntD != '0;
		end
	end
	// data array needs no reset, it is only read when valid
	always_ff @(posedge mclk) begin
		if (push) mem_q[wp_q] <= inData;
	end
endmodule
`default_nettype wire

/* hw/rtci_target.sv */
// Function
// - lines only pulled low or released
// - one bit per clock, change low, sample high
// - data falling while clock high is start
// - data rising while clock high is stop
// - answer only seven-bit address 0110010
// - first byte bit 0 gives direction
// - matching address byte is acknowledged
// - sender releases data for ninth ack clock
// - receiver pulls data low after eighth bit
// - release data after one ack clock
// - any number of bytes per transfer
// - transmitting master stops after last ack
// - receiving master nacks last byte, then stops
// - write: address, register, data bytes, stop
// - write stores at pointer, then increments
// - read: register in write, restart, read
// - read sends pointed register, msb first
// - master ack advances pointer, next byte
// - after a read, resume at last plus one
// - after a write, resume at write's first
`timescale 1ns/100ps
`default_nettype none
module rtci_target (
	input wire logic mclk, // system clock, 20 MHz
	input wire logic rst_n, // async reset, active low
	rtci_if.dev bus, // two-wire link
	output logic [rtci_pkg::BYTE_BITS-1:0] regAddr, // read pointer
	output logic regWrEn, // one-cycle write strobe
	output logic [rtci_pkg::BYTE_BITS-1:0] regWrAddr, // write address
	output logic [rtci_pkg::BYTE_BITS-1:0] regWrData, // write data
	input wire logic [rtci_pkg::BYTE_BITS-1:0] regRdData // data at regAddr
);
	import rtci_pkg::*;

	// pin samplers: meta, synced, previous
	logic sclM_q, sclS_q, sclP_q;
	logic sdaM_q, sdaS_q, sdaP_q;
	rtci_tstate_t state_q; // transfer phase
	logic [3:0] bitCnt_q; // bits done in the current byte
	logic [7:0] shift_q; // byte in or out
	logic sdaOe_q; // we pull data low
	logic txByte_q; // current byte is ours to send
	logic txGo_q; // master wants another byte
	logic [7:0] ptr_q; // register pointer
	logic [7:0] firstW_q; // first register of the last write
	logic [7:0] lastRd_q; // last register sent
	logic wasWrite_q; // previous access was a write
	logic wrEn_q; // write strobe
	logic [7:0] wrAddr_q, wrData_q; // write address and data

	// two flops on each pin before anything looks at it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclM_q <= 1'b1;
			sclS_q <= 1'b1;
			sclP_q <= 1'b1;
			sdaM_q <= 1'b1;
			sdaS_q <= 1'b1;
			sdaP_q <= 1'b1;
		end else begin
			sclM_q <= bus.sclLine;
			sclS_q <= sclM_q;
			sclP_q <= sclS_q;
			sdaM_q <= bus.sdaLine;
			sdaS_q <= sdaM_q;
			sdaP_q <= sdaS_q;
		end
	end

	// edge decode on the synced copies only
	wire sclRise = sclS_q && !sclP_q;
	wire sclFall = !sclS_q && sclP_q;
	wire sclHigh = sclS_q && sclP_q;
	wire startSeen = sclHigh && sdaP_q && !sdaS_q;
	wire stopSeen = sclHigh && !sdaP_q && sdaS_q;
	wire engineOn = state_q != T_IDLE && state_q != T_IGNORE;
	wire byteDone = engineOn && sclFall && bitCnt_q == LAST_BIT;
	wire ackDone = engineOn && sclFall && bitCnt_q == ACK_SLOT;
	wire ackRise = engineOn && sclRise && bitCnt_q == ACK_SLOT;
	wire addrHit = shift_q[7:1] == TGT_ADDR;
	wire dirRead = shift_q[0] == DIR_READ;
	// ack every byte we receive, the address byte only on a match
	wire ackMine = !txByte_q && (state_q != T_ADDR || addrHit);
	wire masterAck = ackRise && txByte_q && !sdaS_q;
	wire loadTx = ackDone && state_q == T_RDATA && txGo_q;
	wire [7:0] readStart = wasWrite_q ? firstW_q : 8'(lastRd_q + 8'h01);

	// phase of the transfer, set by start and stop, by the received address and register bytes, and by a nack to a sent byte
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= T_IDLE;
		end else if (startSeen) begin
			state_q <= T_ADDR;
		end else if (stopSeen) begin
			state_q <= T_IDLE;
		end else if (byteDone && !txByte_q) begin
			case (state_q)
				T_ADDR: begin
					if (!addrHit)
						state_q <= T_IGNORE;
					else if (dirRead)
						state_q <= T_RDATA;
					else
						state_q <= T_REG;
				end
				T_REG: begin
					state_q <= T_WDATA;
				end
				default: begin
					state_q <= state_q;
				end
			endcase
		end else if (ackDone && state_q == T_RDATA && !txGo_q) begin
			state_q <= T_IGNORE;
		end
	end

	// bit engine: count, shift, drive or release the data line
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			sdaOe_q <= 1'b0;
			txByte_q <= 1'b0;
			txGo_q <= 1'b0;
		end else if (startSeen || stopSeen) begin
			// the fall after a start ends no data bit, so it must not count
			bitCnt_q <= BIT_PRE;
			sdaOe_q <= 1'b0;
			txByte_q <= 1'b0;
			txGo_q <= 1'b0;
		end else if (engineOn) begin
			// receiver samples while the clock is high
			if (sclRise && !txByte_q && bitCnt_q < ACK_SLOT)
				shift_q <= {shift_q[6:0], sdaS_q};
			if (ackRise && txByte_q)
				txGo_q <= !sdaS_q;
			if (byteDone && state_q == T_ADDR && addrHit && dirRead)
				txGo_q <= 1'b1;
			if (sclFall)
				bitCnt_q <= ackDone ? 4'h0 : 4'(bitCnt_q + 4'h1);
			if (byteDone) begin
				sdaOe_q <= ackMine;
			end else if (loadTx) begin
				// first bit goes out as soon as the clock is low
				shift_q <= regRdData;
				sdaOe_q <= !regRdData[7];
				txByte_q <= 1'b1;
			end else if (ackDone) begin
				sdaOe_q <= 1'b0;
				txByte_q <= 1'b0;
			end else if (sclFall && txByte_q) begin
				shift_q <= {shift_q[6:0], 1'b0};
				sdaOe_q <= !shift_q[6];
			end
		end
	end

	// pointer bookkeeping; a start without a register byte reuses history
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= PTR_RST;
			firstW_q <= PTR_RST;
			lastRd_q <= PTR_RST;
			wasWrite_q <= 1'b0;
		end else if (byteDone && !txByte_q) begin
			if (state_q == T_ADDR && addrHit && dirRead) begin
				ptr_q <= readStart;
				wasWrite_q <= 1'b0;
			end else if (state_q == T_REG) begin
				ptr_q <= shift_q;
				firstW_q <= shift_q;
				wasWrite_q <= 1'b1;
			end else if (state_q == T_WDATA) begin
				ptr_q <= 8'(ptr_q + 8'h01);
			end
		end else if (masterAck) begin
			ptr_q <= 8'(ptr_q + 8'h01);
		end else if (loadTx) begin
			lastRd_q <= ptr_q;
		end
	end

	// write strobe, one cycle, with the address it was aimed at
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrEn_q <= 1'b0;
			wrAddr_q <= PTR_RST;
			wrData_q <= 8'h00;
		end else begin
			wrEn_q <= byteDone && state_q == T_WDATA && !txByte_q;
			if (byteDone && state_q == T_WDATA) begin
				wrAddr_q <= ptr_q;
				wrData_q <= shift_q;
			end
		end
	end

	// the register file reads the pointer directly, one flop to the pin
	assign regAddr = ptr_q;
	assign regWrEn = wrEn_q;
	assign regWrAddr = wrAddr_q;
	assign regWrData = wrData_q;
	assign bus.sdaDevOe = sdaOe_q;
endmodule
`default_nettype wire

/* test/rtci_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// watches the wire between the host end and the target end
module rtci_chk (
	input wire logic mclk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic sclHostOe, // host pulls clock low
	input wire logic sdaHostOe, // host pulls data low
	input wire logic sdaDevOe, // target pulls data low
	input wire logic sclLine, // resolved clock level
	input wire logic sdaLine // resolved data level
);
	logic sclQ, sdaQ; // line levels one cycle ago
	logic firstQ; // still in the address byte
	logic rwQ; // direction bit of the last address byte
	logic nackQ; // host refused a read byte, stop follows
	logic [3:0] slotQ; // clock rises seen within the current byte
	wire sclRise = sclLine && !sclQ;
	wire startEv = sclLine && sclQ && sdaQ && !sdaLine;
	wire stopEv = sclLine && sclQ && !sdaQ && sdaLine;
	wire ackSlot = sclRise && (slotQ == 4'h8);
	// byte framing rebuilt from the wire, restarted by every start
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{sclQ, sdaQ, firstQ, rwQ, nackQ} <= 5'h18;
			slotQ <= 4'h0;
		end else begin
			{sclQ, sdaQ} <= {sclLine, sdaLine};
			if (startEv) begin
				{firstQ, nackQ} <= 2'h2;
				slotQ <= 4'h0;
			end else if (sclRise) begin
				slotQ <= ackSlot ? 4'h0 : slotQ + 4'h1;
				firstQ <= firstQ && !ackSlot;
				rwQ <= (firstQ && slotQ == 4'h7) ? sdaLine : rwQ;
				nackQ <= nackQ || (ackSlot && rwQ && !firstQ && sdaLine);
			end
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_dev_low; sdaDevOe |-> !sdaLine; endproperty
	a_dev_low: assert property (p_dev_low)
		else $error("target pull does not reach the data line");
	// a change while the clock is high would read as start or stop
	property p_dev_chg; $changed(sdaDevOe) |-> !sclLine && !$past(sclLine, 2);
	endproperty
	a_dev_chg: assert property (p_dev_chg)
		else $error("target moved data outside the clock low time");
	property p_start_quiet; startEv |-> !sdaDevOe [*8]; endproperty
	a_start_quiet: assert property (p_start_quiet)
		else $error("target drives data right after a start");
	property p_stop_quiet; stopEv |-> !sdaDevOe [*8]; endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("target drives data right after a stop");
	property p_ack_written; ackSlot && (firstQ || !rwQ) |-> !sdaLine;
	endproperty
	a_ack_written: assert property (p_ack_written)
		else $error("byte from host not acknowledged");
	property p_ack_held; $rose(sdaDevOe) |-> sdaDevOe [*8]; endproperty
	a_ack_held: assert property (p_ack_held)
		else $error("target low level too short");
	property p_ack_release; ackSlot && !rwQ |-> ##[1:40] !sdaDevOe;
	endproperty
	a_ack_release: assert property (p_ack_release)
		else $error("target kept data after its acknowledge");
	property p_host_quiet_rd;
		sclRise && !firstQ && rwQ && !nackQ && slotQ != 4'h8 |-> !sdaHostOe;
	endproperty
	a_host_quiet_rd: assert property (p_host_quiet_rd)
		else $error("host drives data while target sends");
	c_wr_ack: cover property (ackSlot && !firstQ && !rwQ);
	c_rd_data: cover property (sclRise && !firstQ && rwQ);
	c_stop: cover property (stopEv);
endmodule
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import rtci_pkg::*;
	logic mclk, rst_n; // clock, reset
	logic cmdValid, cmdRead, cmdSetReg, wrValid, rdReady; // host command side
	logic [7:0] cmdReg, cmdLen, wrData, rdData; // host data
	logic cmdReady, wrReady, rdValid, doneStb, nackSeen; // host replies
	logic [7:0] regAddr, regWrAddr, regWrData; // target register port
	logic regWrEn; // target write strobe
	logic [7:0] mem [256]; // register file behind the target
	logic [7:0] expMem [256]; // expected register contents
	logic ack, s; // bench-side wire results
	int error_cnt, cmp_count, doneCnt;
	rtci_if busA (); // host end to target end
	rtci_if busB (); // bench to spare target, for faults
	rtci_host u_rtci_host (.mclk(mclk), .rst_n(rst_n), .bus(busA),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead),
		.cmdSetReg(cmdSetReg), .cmdReg(cmdReg), .cmdLen(cmdLen),
		.wrValid(wrValid), .wrData(wrData), .wrReady(wrReady),
		.rdValid(rdValid), .rdData(rdData), .rdReady(rdReady),
		.doneStb(doneStb), .nackSeen(nackSeen));
	rtci_target u_rtci_target (.mclk(mclk), .rst_n(rst_n), .bus(busA),
		.regAddr(regAddr), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
		.regWrData(regWrData), .regRdData(mem[regAddr]));
	rtci_target u_rtci_target_b (.mclk(mclk), .rst_n(rst_n), .bus(busB),
		.regAddr(), .regWrEn(), .regWrAddr(), .regWrData(),
		.regRdData(8'h00));
	rtci_chk u_rtci_chk (.mclk(mclk), .rst_n(rst_n),
		.sclHostOe(busA.sclHostOe), .sdaHostOe(busA.sdaHostOe),
		.sdaDevOe(busA.sdaDevOe), .sclLine(busA.sclLine),
		.sdaLine(busA.sdaLine));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// register file and transfer-end counter
	always @(posedge mclk) begin
		if (regWrEn === 1'b1) mem[regWrAddr] <= regWrData;
		if (doneStb === 1'b1) doneCnt <= doneCnt + 1;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		cmp_count++;
		if (got !== want) begin
			error_cnt++;
			$display("ERROR %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic tally_and_finish();
		$display("%0d compares, %0d mismatches", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic hang();
		error_cnt++;
		$display("ERROR %0t: wait ran out", $time);
		tally_and_finish();
	endtask
	// command offered at a falling edge, taken at the rise with ready high
	task automatic sendCmd(input logic rd, input logic setReg,
		input logic [7:0] rg, input int len);
		int n;
		@(negedge mclk);
		{cmdValid, cmdRead, cmdSetReg} = {1'b1, rd, setReg};
		{cmdReg, cmdLen} = {rg, 8'(len)};
		for (n = 0; cmdReady !== 1'b1; n++) begin
			if (n > 100) hang();
			@(negedge mclk);
		end
		@(negedge mclk);
		cmdValid = 1'b0;
	endtask
	task automatic waitDone(input int d0);
		for (int n = 0; doneCnt == d0; n++) begin
			if (n > 20000) hang();
			@(negedge mclk);
		end
	endtask
	// each byte held until the host takes it with its ready pulse
	task automatic hostWrite(input logic [7:0] rg, input int len);
		int d0;
		d0 = doneCnt;
		wrValid = 1'b1;
		sendCmd(1'b0, 1'b1, rg, len);
		for (int i = 0; i < len; i++) begin
			wrData = (rg + 8'(i)) ^ 8'h5c;
			expMem[rg + 8'(i)] = wrData;
			for (int n = 0; wrReady !== 1'b1; n++) begin
				if (n > 2000) hang();
				@(negedge mclk);
			end
			@(negedge mclk);
		end
		wrValid = 1'b0;
		waitDone(d0);
	endtask
	// stall holds the drain off long enough for the buffer to refuse
	task automatic hostRead(input logic setReg, input logic [7:0] rg,
		input int len, input logic [7:0] first, input logic stall);
		int d0;
		d0 = doneCnt;
		rdReady = !stall;
		sendCmd(1'b1, setReg, rg, len);
		if (stall) begin
			repeat (8000) @(negedge mclk);
			chk(8'(cmdReady), 8'h00);
			rdReady = 1'b1;
		end
		for (int i = 0; i < len; i++) begin
			for (int n = 0; rdValid !== 1'b1; n++) begin
				if (n > 4000) hang();
				@(negedge mclk);
			end
			chk(rdData, expMem[first + 8'(i)]);
			@(negedge mclk);
		end
		waitDone(d0);
	endtask
	// bench-made link clock: 4 system clocks a phase, 400 ns a bit
	task automatic ph();
		repeat (4) @(negedge mclk);
	endtask
	task automatic bbStart();
		busB.sdaHostOe = 1'b0;
		ph();
		busB.sclHostOe = 1'b0;
		ph();
		busB.sdaHostOe = 1'b1;
		ph();
		busB.sclHostOe = 1'b1;
	endtask
	task automatic bbBit(input logic b);
		busB.sdaHostOe = !b;
		ph();
		busB.sclHostOe = 1'b0;
		ph();
		s = busB.sdaLine;
		busB.sclHostOe = 1'b1;
	endtask
	task automatic bbByte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) bbBit(v[i]);
		bbBit(1'b1);
		ack = !s;
	endtask
	task automatic bbStop();
		busB.sdaHostOe = 1'b1;
		ph();
		busB.sclHostOe = 1'b0;
		ph();
		busB.sdaHostOe = 1'b0;
		ph();
	endtask
	initial begin
		{error_cnt, cmp_count, doneCnt} = '0;
		{rst_n, cmdValid, cmdRead, cmdSetReg, wrValid, rdReady} = '0;
		{cmdReg, cmdLen, wrData} = '0;
		{busB.sclHostOe, busB.sdaHostOe} = 2'h0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h3a;
			expMem[i] = 8'(i) ^ 8'h3a;
		end
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		hostRead(1'b0, 8'h00, 2, 8'h01, 1'b0);
		hostRead(1'b0, 8'h00, 1, 8'h03, 1'b0);
		$display("current-address reads done");
		hostWrite(8'h40, 3);
		for (int i = 0; i < 3; i++) begin
			chk(mem[8'h40 + 8'(i)], expMem[8'h40 + 8'(i)]);
		end
		chk(8'(nackSeen), 8'h00);
		hostRead(1'b0, 8'h00, 2, 8'h40, 1'b0);
		$display("write and read-after-write done");
		hostRead(1'b1, 8'h00, 34, 8'h00, 1'b1);
		hostRead(1'b0, 8'h00, 1, 8'h22, 1'b0);
		$display("long stalled read done");
		// each address one bit off is ignored up to a repeated start
		for (int b = 0; b < 7; b++) begin
			bbStart();
			bbByte({TGT_ADDR ^ (7'h01 << b), DIR_WRITE});
			chk(8'(ack), 8'h00);
			bbByte(8'h00);
			chk(8'(ack), 8'h00);
			bbStart();
			bbByte({TGT_ADDR, DIR_WRITE});
			chk(8'(ack), 8'h01);
			bbStop();
		end
		// a start half-way through a byte restarts the count
		bbStart();
		bbByte({TGT_ADDR, DIR_WRITE});
		for (int i = 0; i < 4; i++) bbBit(1'b0);
		bbStart();
		bbByte({TGT_ADDR, DIR_READ});
		chk(8'(ack), 8'h01);
		bbByte(8'hff);
		chk(8'(ack), 8'h00);
		bbStop();
		$display("address and abort tests done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
